// [rtl/msa_crc_byte.sv]
// Purpose: One-octet step of the reflected CRC-32 used for hashing.
// Assumes: Octets arrive least significant bit first on the wire.
// Notes:   Pure combinational.
`timescale 1ns/100ps
module msa_crc_byte (
    input  wire logic [31:0] crc_in,
    input  wire logic [7:0]  octet,
    output logic      [31:0] crc_out
);
    always_comb begin
        logic [31:0] c;
        c = crc_in;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ octet[i]) begin
                c = (c >> 1) ^ msa_pkg::CRC_POLY_REFL;
            end else begin
                c = c >> 1;
            end
        end
        crc_out = c;
    end
endmodule

// [rtl/msa_filter.sv]
// Purpose: APB register bank plus destination address filter.
// Assumes: rx_sof marks the first destination octet; octets arrive on rx_valid.
// Notes:   Verdict is issued once, after the sixth destination octet.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module msa_filter (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        soft_rst,
    input  wire logic        reset_protect,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_frame_ready,
    output logic             tx_frame_go,
    input  wire logic        rx_valid,
    input  wire logic        rx_sof,
    input  wire logic [7:0]  rx_data,
    output logic             rx_accept_en,
    output logic             filter_done,
    output logic             filter_pass,
    output logic             filter_unicast_hit,
    output logic             filter_group_hit,
    output logic      [5:0]  hash_index
);
    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic                  transmit_enable;
    logic                  receive_enable;
    logic                  pass_all_group_frames;
    logic [15:0]           station_address_upper;
    logic [31:0]           station_address_lower;
    logic [31:0]           group_hash_upper;
    logic [31:0]           group_hash_lower;
    logic                  wr_en;
    logic                  rd_en;
    logic                  addr_hit;
    logic [31:0]           rd_mux;
    logic [31:0]           wmask;

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    // Read data is captured in the setup phase so that the flop output
    // already stands when the master samples it together with pready
    assign rd_en   = psel & ~penable & ~pwrite;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    // Unmapped addresses read zero and flag an error
    always_comb begin
        addr_hit = 1'b1;
        rd_mux   = 32'h00000000;
        if (paddr == msa_pkg::MAC_CONTROL_OFS) begin
            rd_mux[msa_pkg::TX_EN_BIT]    = transmit_enable;
            rd_mux[msa_pkg::RX_EN_BIT]    = receive_enable;
            rd_mux[msa_pkg::PASS_ALL_BIT] = pass_all_group_frames;
        end else if (paddr == msa_pkg::ADDR_UPPER_OFS) begin
            rd_mux = {16'h0000, station_address_upper};
        end else if (paddr == msa_pkg::ADDR_LOWER_OFS) begin
            rd_mux = station_address_lower;
        end else if (paddr == msa_pkg::HASH_UPPER_OFS) begin
            rd_mux = group_hash_upper;
        end else if (paddr == msa_pkg::HASH_LOWER_OFS) begin
            rd_mux = group_hash_lower;
        end else begin
            addr_hit = 1'b0;
        end
    end

    assign pslverr = psel & penable & ~addr_hit;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Control bits are cleared by soft reset too
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            transmit_enable       <= 1'b0;
            receive_enable        <= 1'b0;
            pass_all_group_frames <= 1'b0;
        end else if (soft_rst) begin
            transmit_enable       <= 1'b0;
            receive_enable        <= 1'b0;
            pass_all_group_frames <= 1'b0;
        end else if (wr_en && paddr == msa_pkg::MAC_CONTROL_OFS) begin
            if (pstrb[0]) begin
                transmit_enable <= pwdata[msa_pkg::TX_EN_BIT];
                receive_enable  <= pwdata[msa_pkg::RX_EN_BIT];
            end
            if (pstrb[2]) begin
                pass_all_group_frames <= pwdata[msa_pkg::PASS_ALL_BIT];
            end
        end
    end

    // Station address survives a soft reset while protection is on
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            station_address_upper <= msa_pkg::ADDR_UPPER_RST;
            station_address_lower <= msa_pkg::ADDR_LOWER_RST;
        end else if (soft_rst) begin
            if (!reset_protect) begin
                station_address_upper <= msa_pkg::ADDR_UPPER_RST;
                station_address_lower <= msa_pkg::ADDR_LOWER_RST;
            end
        end else if (wr_en) begin
            if (paddr == msa_pkg::ADDR_UPPER_OFS) begin
                station_address_upper <= (station_address_upper & ~wmask[15:0])
                                       | (pwdata[15:0] & wmask[15:0]);
            end
            if (paddr == msa_pkg::ADDR_LOWER_OFS) begin
                station_address_lower <= (station_address_lower & ~wmask)
                                       | (pwdata & wmask);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            group_hash_upper <= msa_pkg::HASH_RST;
            group_hash_lower <= msa_pkg::HASH_RST;
        end else if (soft_rst) begin
            group_hash_upper <= msa_pkg::HASH_RST;
            group_hash_lower <= msa_pkg::HASH_RST;
        end else if (wr_en) begin
            if (paddr == msa_pkg::HASH_UPPER_OFS) begin
                group_hash_upper <= (group_hash_upper & ~wmask) | (pwdata & wmask);
            end
            if (paddr == msa_pkg::HASH_LOWER_OFS) begin
                group_hash_lower <= (group_hash_lower & ~wmask) | (pwdata & wmask);
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit gate
    // ------------------------------------------------------------------
    // gate transmit start
    assign tx_frame_go  = transmit_enable & tx_frame_ready;
    assign rx_accept_en = receive_enable;

    // ------------------------------------------------------------------
    // Destination address filter
    // ------------------------------------------------------------------
    msa_pkg::msa_rx_state_e state;
    msa_pkg::msa_rx_state_e next_state;
    logic [2:0]            octet_cnt;
    logic [31:0]           crc;
    logic [31:0]           crc_step;
    logic [31:0]           crc_seed;
    logic                  match_so_far;
    logic                  group_bit;
    logic [7:0]            expect_octet;
    logic                  take;
    logic                  last_octet;
    logic                  match_now;
    logic [5:0]            idx;
    logic                  sel_bit;

    // Frames starting while receive is off are ignored entirely
    assign take       = rx_valid & receive_enable &
                        ((state == msa_pkg::MSA_DEST) | rx_sof);
    assign last_octet = take & (rx_sof ? 1'b0 : (octet_cnt == msa_pkg::DEST_OCTETS - 3'h1));
    assign crc_seed   = rx_sof ? msa_pkg::CRC_INIT : crc;

    always_comb begin
        case (rx_sof ? 3'h0 : octet_cnt)
            3'h0:    expect_octet = station_address_lower[7:0];
            3'h1:    expect_octet = station_address_lower[15:8];
            3'h2:    expect_octet = station_address_lower[23:16];
            3'h3:    expect_octet = station_address_lower[31:24];
            3'h4:    expect_octet = station_address_upper[7:0];
            default: expect_octet = station_address_upper[15:8];
        endcase
    end

    assign match_now = (rx_sof ? 1'b1 : match_so_far) & (rx_data == expect_octet);

    msa_crc_byte u_crc (
        .crc_in  (crc_seed),
        .octet   (rx_data),
        .crc_out (crc_step)
    );

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            idx[i] = ~crc_step[31 - i];
        end
    end

    assign sel_bit = idx[5] ? group_hash_upper[idx[4:0]] : group_hash_lower[idx[4:0]];

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            msa_pkg::MSA_IDLE: begin
                if (take) begin
                    next_state = msa_pkg::MSA_DEST;
                end
            end
            msa_pkg::MSA_DEST: begin
                if (last_octet) begin
                    next_state = msa_pkg::MSA_BODY;
                end
            end
            msa_pkg::MSA_BODY: begin
                if (take) begin
                    next_state = msa_pkg::MSA_DEST;
                end
            end
            default: next_state = msa_pkg::MSA_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= msa_pkg::MSA_IDLE;
        end else if (!receive_enable) begin
            state <= msa_pkg::MSA_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            octet_cnt    <= 3'h0;
            crc          <= msa_pkg::CRC_INIT;
            match_so_far <= 1'b0;
            group_bit    <= 1'b0;
        end else if (take) begin
            octet_cnt    <= rx_sof ? 3'h1 : octet_cnt + 3'h1;
            crc          <= crc_step;
            match_so_far <= match_now;
            if (rx_sof) begin
                group_bit <= rx_data[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            filter_done        <= 1'b0;
            filter_pass        <= 1'b0;
            filter_unicast_hit <= 1'b0;
            filter_group_hit   <= 1'b0;
            hash_index         <= 6'h00;
        end else begin
            filter_done <= last_octet;
            if (last_octet) begin
                hash_index <= idx;
                filter_unicast_hit <= ~group_bit & match_now;
                filter_group_hit   <= group_bit & (sel_bit | pass_all_group_frames);
                filter_pass        <= group_bit ? (sel_bit | pass_all_group_frames)
                                                : match_now;
            end
        end
    end
endmodule

// [rtl/msa_pkg.sv]
// Purpose: Constants for the station address and group hash filter block.
// Assumes: APB slave, 32-bit data, byte addresses as printed.
// Notes:   Control register offset and pass-all bit position are local choices.
//
// How it works
// - Transmit enable bit 3 gates frame sending
// - Receive enable bit 2 gates frame reception
// - Upper address in low 16 bits, ones
// - Lower address 32 bits, reset all ones
// - Octets compared in reception byte order
// - Destination derived index picks hash bit
// - Index MSB picks register, five pick bit
// - Selected hash bit one accepts group frame
// - Pass-all bit accepts every group frame
// - Hash registers read-write, reset zero
// - Protect input keeps address through soft reset
package msa_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] MAC_CONTROL_OFS  = 12'h100;
    localparam logic [11:0] ADDR_UPPER_OFS   = 12'h104;
    localparam logic [11:0] ADDR_LOWER_OFS   = 12'h108;
    localparam logic [11:0] HASH_UPPER_OFS   = 12'h10c;
    localparam logic [11:0] HASH_LOWER_OFS   = 12'h110;
    // ------------------------------------------------------------------
    // Fields and resets
    // ------------------------------------------------------------------
    localparam int          RX_EN_BIT        = 2;
    localparam int          TX_EN_BIT        = 3;
    localparam int          PASS_ALL_BIT     = 19;
    localparam logic [15:0] ADDR_UPPER_RST   = 16'hffff;
    localparam logic [31:0] ADDR_LOWER_RST   = 32'hffffffff;
    localparam logic [31:0] HASH_RST         = 32'h00000000;
    localparam logic [31:0] CRC_INIT         = 32'hffffffff;
    localparam logic [31:0] CRC_POLY_REFL    = 32'hedb88320;
    localparam logic [2:0]  DEST_OCTETS      = 3'h6;
    typedef enum logic [1:0] {
        MSA_IDLE = 2'b00,
        MSA_DEST = 2'b01,
        MSA_BODY = 2'b10
    } msa_rx_state_e;
endpackage

// [verif/msa_filter_asserts.sv]
// Purpose: Port-level checks for msa_filter.
// Assumes: One clock domain, rst async high.
// Notes:   Verdict outputs are judged at filter_done and held stable in every cycle without it.
`timescale 1ns/100ps
module msa_filter_asserts (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        tx_frame_ready,
    input wire logic        tx_frame_go,
    input wire logic        rx_valid,
    input wire logic        rx_accept_en,
    input wire logic        filter_done,
    input wire logic        filter_pass,
    input wire logic        filter_unicast_hit,
    input wire logic        filter_group_hit,
    input wire logic [5:0]  hash_index
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_TX_GATE: assert property (!tx_frame_ready |-> !tx_frame_go)
        else $error("tx go without frame");
    AST_RX_CAUSE: assert property (filter_done |-> $past(rx_valid) && $past(rx_accept_en))
        else $error("verdict without accepted octet");
    AST_DONE_PULSE: assert property (filter_done |=> !filter_done)
        else $error("done longer than one cycle");
    AST_VERDICT_HOLD: assert property (
        !filter_done |-> $stable({filter_pass, filter_group_hit, filter_unicast_hit}))
        else $error("verdict moved between frames");
    AST_INDEX_HOLD: assert property (!filter_done |-> $stable(hash_index))
        else $error("index moved between frames");
    AST_PASS_SUM: assert property (
        filter_done |-> filter_pass == (filter_unicast_hit || filter_group_hit))
        else $error("pass differs from hits");
    AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    AST_RDATA_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without read");
endmodule

bind msa_filter msa_filter_asserts u_msa_filter_asserts (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pslverr(pslverr), .tx_frame_ready(tx_frame_ready),
    .tx_frame_go(tx_frame_go), .rx_valid(rx_valid), .rx_accept_en(rx_accept_en),
    .filter_done(filter_done), .filter_pass(filter_pass),
    .filter_unicast_hit(filter_unicast_hit), .filter_group_hit(filter_group_hit),
    .hash_index(hash_index)
);

// [verif/msa_filter_tb_top.sv]
// Purpose: Self-checking bench for msa_filter.
// Assumes: pready answers at once; prdata stands through the access phase.
// Notes:   Register images and verdicts are reckoned in the bench.
`timescale 1ns/100ps
module msa_filter_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        soft_rst = 1'b0;
    logic        reset_protect = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic        tx_frame_ready = 1'b0;
    logic [31:0] prdata, rdv, mdl [5];
    logic [31:0] seed = 32'h29ca;
    logic        pready, pslverr, tx_frame_go, rx_valid, rx_sof, rx_accept_en, errv;
    logic        filter_done, filter_pass, filter_unicast_hit, filter_group_hit;
    logic [5:0]  hash_index;
    logic [7:0]  rx_data;
    int          error_cnt = 0;
    int          check_count = 0;
    always #12.5 ref_clk = ~ref_clk;
    msa_filter u_msa_filter (
        .ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst), .reset_protect(reset_protect),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_frame_ready(tx_frame_ready), .tx_frame_go(tx_frame_go), .rx_valid(rx_valid),
        .rx_sof(rx_sof), .rx_data(rx_data), .rx_accept_en(rx_accept_en),
        .filter_done(filter_done), .filter_pass(filter_pass),
        .filter_unicast_hit(filter_unicast_hit), .filter_group_hit(filter_group_hit),
        .hash_index(hash_index)
    );
    msa_phy_model u_msa_phy_model (
        .ref_clk(ref_clk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data)
    );
    // ---------------
    // Model and tasks
    // ---------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [47:0] r48();
        logic [31:0] h;
        h = rnd();
        return {h[15:0], rnd()};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        errv = pslverr;
        rdv  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input int i, input logic [31:0] d);
        apb(1'b1, 12'h100 + 12'(4 * i), d);
        chk("wr_pslverr", 32'(i > 4), 32'(errv));
        if (i < 5) mdl[i] = d & (i == 0 ? 32'h0008000c : (i == 1 ? 32'h0000ffff : '1));
    endtask
    task automatic rall();
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'h100 + 12'(4 * i), 32'h0);
            chk("prdata", i < 5 ? mdl[i] : 32'h0, rdv);
            chk("pslverr", 32'(i > 4), 32'(errv));
        end
    endtask
    task automatic mreset(input logic keep);
        mdl[0] = 32'h0;
        mdl[3] = 32'h0;
        mdl[4] = 32'h0;
        if (!keep) begin
            mdl[1] = 32'h0000ffff;
            mdl[2] = 32'hffffffff;
        end
    endtask
    task automatic srst(input logic keep);
        @(posedge ref_clk);
        reset_protect <= keep;
        soft_rst      <= 1'b1;
        @(posedge ref_clk);
        soft_rst      <= 1'b0;
        mreset(keep);
        rall();
        $display("soft reset test done");
    endtask
    task automatic frame(input logic [47:0] da);
        logic [31:0] c;
        logic [5:0]  ix;
        logic        uh, gh;
        int          n;
        c = 32'hffffffff;
        for (int i = 0; i < 48; i++) c = (c >> 1) ^ (c[0] ^ da[i] ? 32'hedb88320 : 32'h0);
        for (int i = 0; i < 6; i++) ix[i] = ~c[31 - i];
        uh = ~da[0] & (da === {mdl[1][15:0], mdl[2]});
        gh = da[0] & (mdl[0][19] | (ix[5] ? mdl[3][ix[4:0]] : mdl[4][ix[4:0]]));
        u_msa_phy_model.send(da, int'(rnd() % 3));
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (filter_done !== 1'b1 && n < 4);
        if (mdl[0][2]) begin
            chk("verdict", 32'({1'b1, ix, uh, gh, uh | gh}), 32'({filter_done, hash_index,
                filter_unicast_hit, filter_group_hit, filter_pass}));
        end else begin
            chk("done", 32'h0, 32'(filter_done));
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // --------
    // Stimulus
    // --------
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        mreset(1'b0);
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rall();
        $display("reset value test done");
        for (int i = 0; i < 6; i++) wr(i, 32'hffffffff);
        rall();
        $display("access test done");
        for (int k = 0; k < 4; k++) begin
            wr(0, {28'h0, 2'(k), 2'b00});
            // Toggled on the edge that ends the write, ahead of the check
            tx_frame_ready <= ~tx_frame_ready;
            @(negedge ref_clk);
            chk("tx_go", 32'(k[1] & tx_frame_ready), 32'(tx_frame_go));
            chk("rx_en", 32'(k[0]), 32'(rx_accept_en));
        end
        $display("enable test done");
        wr(1, rnd());
        wr(2, rnd() & 32'hfffffffe);
        wr(3, rnd());
        wr(4, rnd());
        wr(0, 32'h4);
        frame({mdl[1][15:0], mdl[2]});
        frame({mdl[1][15:0] ^ 16'h8000, mdl[2]});
        for (int k = 0; k < 32; k++) frame(r48() | 48'(k & 1));
        wr(0, 32'h00080004);
        for (int k = 0; k < 6; k++) frame(r48() | 48'h1);
        wr(0, 32'h0);
        frame(r48());
        $display("filter test done");
        srst(1'b1);
        srst(1'b0);
        conclude();
    end
endmodule

// [verif/msa_phy_model.sv]
// Purpose: Receive path model feeding destination octets.
// Assumes: Octets go out in reception order, lowest byte first.
// Notes:   Gap cycles show inverted data so stale octets never match.
`timescale 1ns/100ps
module msa_phy_model (
    input  wire logic       ref_clk,
    output logic            rx_valid,
    output logic            rx_sof,
    output logic      [7:0] rx_data
);
    initial begin
        rx_valid = 1'b0;
        rx_sof   = 1'b0;
        rx_data  = 8'h00;
    end
    task automatic send(input logic [47:0] da, input int gap);
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            rx_valid <= 1'b1;
            rx_sof   <= (i == 0);
            rx_data  <= da[8 * i +: 8];
            for (int g = 0; g < gap && i < 5; g++) begin
                @(posedge ref_clk);
                rx_valid <= 1'b0;
                rx_sof   <= 1'b0;
                rx_data  <= ~da[8 * i +: 8];
            end
        end
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_sof   <= 1'b0;
        rx_data  <= ~da[47:40];
    endtask
endmodule
